// *** pkg/twsp_regs.vh ***
// register map, field positions and reset values of the two-wire serial port core
`ifndef TWSP_REGS_VH
`define TWSP_REGS_VH
// register offsets
`define TWSP_OFS_STATUS    3'h0
`define TWSP_OFS_CTRL      3'h1
`define TWSP_OFS_MODE2     3'h2
`define TWSP_OFS_DATA      3'h3
`define TWSP_OFS_ADDR      3'h4
// port_status fields
`define TWSP_ST_BF         0
`define TWSP_ST_RW         2
`define TWSP_ST_START      3
`define TWSP_ST_STOP       4
`define TWSP_ST_IRQ        5
`define TWSP_ST_WRITE_COLLISION       6
`define TWSP_ST_BCOL       7
// control fields
`define TWSP_CT_ENABLE     7
`define TWSP_CT_OVF        6
`define TWSP_CT_EDGE       5
`define TWSP_CT_RELEASE    4
`define TWSP_CT_STRETCH    3
`define TWSP_CT_WAKE       2
`define TWSP_CT_IRQEN      1
`define TWSP_CT_MASTER     0
// mode_control_two fields
`define TWSP_M2_GENERAL_CALL_ENABLE       7
`define TWSP_M2_ACKSTAT    6
`define TWSP_M2_ACKVAL     5
`define TWSP_M2_ACKREQ     4
`define TWSP_M2_RCEN       3
`define TWSP_M2_STOPREQ    2
`define TWSP_M2_RSREQ      1
`define TWSP_M2_STARTREQ   0
// reset value and general call address
`define TWSP_RST_BYTE      8'h00
`define TWSP_GC_ADDR       7'h00
// bit counts within a byte frame
`define TWSP_BIT_LAST      4'h8
`define TWSP_BIT_ACK       4'h9
`endif

// *** rtl/twsp_core.v ***
// two-wire serial port core: slave and master condition sequencer with register port
//
// Operation
// - write address match clears direction, buffers address
// - slave receive: byte per eight clocks, optional stretch
// - receive latch edge selectable, rising default
// - full or overflow withholds ack, flag always
// - read match: direction set, ack, hold clock
// - buffer write loads shifter; release shifts out
// - transmit flag on ninth clock, software clears
// - master ack high ends, low continues
// - general call compares against all-zero address
// - general call buffers byte, flag ninth fall
// - power down match: nack, wake pulse and wake bit set, nothing buffered
// - power down mismatch: nack, stay asleep
// - start and stop bits clear when disabled
// - master events raise flag; enable gates interrupt
// - master needs select and enable bits
// - counter reloads low address bits, waits high clock
// - clock rate is cpu clock over twice reload
// - start: lines high, period, data low, period
// - buffer write during sequence sets collision flag
// - restart: release data, release clock, data low
// - restart ignored when busy; low data collides
// - ack sequence drives value, pulses clock, idles
// - stop: data low, clock up, data up, flag
// - buffer read clears full; overflow software cleared
// - ack value zero acks, one does not
`include "twsp_regs.vh"
`default_nettype none
module twsp_core (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// register port
	input  wire [2:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       we_i,
	input  wire       re_i,
	output reg  [7:0] rdata_o,
	// bus pins, open drain
	input  wire       scl_i,
	output reg        scl_o,
	output reg        scl_oe_o,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe_o,
	// system
	input  wire       power_down_i,
	output reg        wake_o,
	output reg        irq_o
);
	localparam SL_IDLE = 3'd0;
	localparam SL_ADDR = 3'd1;
	localparam SL_RX   = 3'd2;
	localparam SL_TX   = 3'd3;
	localparam SL_WAIT = 3'd4;

	localparam M_IDLE = 4'd0;
	localparam M_S1   = 4'd1;
	localparam M_S2   = 4'd2;
	localparam M_RS1  = 4'd3;
	localparam M_RS2  = 4'd4;
	localparam M_RS3  = 4'd5;
	localparam M_A1   = 4'd6;
	localparam M_A2   = 4'd7;
	localparam M_A3   = 4'd8;
	localparam M_P1   = 4'd9;
	localparam M_P2   = 4'd10;
	localparam M_P3   = 4'd11;

	reg [7:0] status_reg;
	reg [7:0] ctrl_reg;
	reg [7:0] mode2_reg;
	reg [7:0] buf_reg;
	reg [7:0] addr_reg;
	reg [7:0] sr_reg;
	reg [2:0] sl_state_reg;
	reg [3:0] bitcnt_reg;
	reg       ack_drv_reg;
	reg       tx_en_reg;
	reg       stretch_reg;
	reg [3:0] m_state_reg;
	reg [6:0] rate_down_counter_reg;
	reg       m_scl_low_reg;
	reg       m_sda_low_reg;
	reg       scl_m_reg;
	reg       scl_s_reg;
	reg       scl_d_reg;
	reg       sda_m_reg;
	reg       sda_s_reg;
	reg       sda_d_reg;

	wire       port_enable   = ctrl_reg[`TWSP_CT_ENABLE];
	wire       master_on     = port_enable & ctrl_reg[`TWSP_CT_MASTER];
	wire       slave_on      = port_enable & ~ctrl_reg[`TWSP_CT_MASTER];
	wire       edge_sel      = ctrl_reg[`TWSP_CT_EDGE];
	wire       scl_rise      = scl_s_reg & ~scl_d_reg;
	wire       scl_fall      = ~scl_s_reg & scl_d_reg;
	wire       bus_start     = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
	wire       bus_stop      = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
	wire [7:0] sh_in         = {sr_reg[6:0], sda_s_reg};
	wire [7:0] rx_byte       = (sl_state_reg == SL_RX && edge_sel) ? sh_in : sr_reg;
	wire       own_hit       = rx_byte[7:1] == addr_reg[7:1];
	wire       gc_hit        = mode2_reg[`TWSP_M2_GENERAL_CALL_ENABLE] & (rx_byte[7:1] == `TWSP_GC_ADDR);
	wire       bad_rx        = status_reg[`TWSP_ST_BF] | ctrl_reg[`TWSP_CT_OVF];
	wire       rate_tick     = rate_down_counter_reg == 7'h00;
	wire [6:0] reload_val    = (addr_reg[6:0] == 7'h00) ? 7'h00 : addr_reg[6:0] - 7'h01;
	wire       m_busy        = m_state_reg != M_IDLE;
	wire       scl_oe_next   = m_scl_low_reg | stretch_reg;
	wire       sda_oe_next   = m_sda_low_reg | ack_drv_reg | (tx_en_reg & ~sr_reg[7]);
	wire       wr_status     = we_i & (addr_i == `TWSP_OFS_STATUS);
	wire       wr_ctrl       = we_i & (addr_i == `TWSP_OFS_CTRL);
	wire       wr_mode2      = we_i & (addr_i == `TWSP_OFS_MODE2);
	wire       wr_data       = we_i & (addr_i == `TWSP_OFS_DATA);
	wire       wr_addr       = we_i & (addr_i == `TWSP_OFS_ADDR);
	wire       rd_data       = re_i & (addr_i == `TWSP_OFS_DATA);

	// two-stage input synchronisers plus one history stage for edges
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_m_reg <= scl_i;
			scl_s_reg <= scl_m_reg;
			scl_d_reg <= scl_s_reg;
			sda_m_reg <= sda_i;
			sda_s_reg <= sda_m_reg;
			sda_d_reg <= sda_s_reg;
		end
	end

	// register read port, data one cycle after the strobe
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= `TWSP_RST_BYTE;
		else if (re_i)
		begin
			case (addr_i)
				`TWSP_OFS_STATUS: rdata_o <= status_reg;
				`TWSP_OFS_CTRL:   rdata_o <= ctrl_reg;
				`TWSP_OFS_MODE2:  rdata_o <= mode2_reg;
				`TWSP_OFS_DATA:   rdata_o <= buf_reg;
				`TWSP_OFS_ADDR:   rdata_o <= addr_reg;
				default:          rdata_o <= `TWSP_RST_BYTE;
			endcase
		end
		else
			rdata_o <= `TWSP_RST_BYTE;
	end

	// pins and interrupt straight from flops
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			irq_o    <= 1'b0;
		end
		else
		begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= scl_oe_next;
			sda_oe_o <= sda_oe_next;
			irq_o    <= status_reg[`TWSP_ST_IRQ] & ctrl_reg[`TWSP_CT_IRQEN];
		end
	end

	// software writes first; hardware sets further down win on the same edge
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status_reg            <= `TWSP_RST_BYTE;
			ctrl_reg              <= `TWSP_RST_BYTE;
			mode2_reg             <= `TWSP_RST_BYTE;
			buf_reg               <= `TWSP_RST_BYTE;
			addr_reg              <= `TWSP_RST_BYTE;
			sr_reg                <= `TWSP_RST_BYTE;
			sl_state_reg          <= SL_IDLE;
			bitcnt_reg            <= 4'h0;
			ack_drv_reg           <= 1'b0;
			tx_en_reg             <= 1'b0;
			stretch_reg           <= 1'b0;
			m_state_reg           <= M_IDLE;
			rate_down_counter_reg <= 7'h00;
			m_scl_low_reg         <= 1'b0;
			m_sda_low_reg         <= 1'b0;
			wake_o                <= 1'b0;
		end
		else
		begin
			wake_o <= 1'b0;
			if (wr_status)
				status_reg[7:5] <= wdata_i[7:5];
			if (wr_ctrl)
				ctrl_reg <= wdata_i;
			if (wr_addr)
				addr_reg <= wdata_i;
			if (wr_mode2)
			begin
				mode2_reg[7] <= wdata_i[7];
				mode2_reg[5] <= wdata_i[5];
				mode2_reg[3] <= wdata_i[3];
				if (!m_busy && !(|mode2_reg[2:0]) && !mode2_reg[4])
				begin
					mode2_reg[4]   <= wdata_i[4];
					mode2_reg[2:0] <= wdata_i[2:0];
				end
			end
			if (rd_data)
				status_reg[`TWSP_ST_BF] <= 1'b0;
			if (wr_data)
			begin
				if (master_on && m_busy)
					status_reg[`TWSP_ST_WRITE_COLLISION] <= 1'b1;
				else
				begin
					buf_reg <= wdata_i;
					if (sl_state_reg == SL_TX)
						sr_reg <= wdata_i;
				end
			end
			if (rate_down_counter_reg != 7'h00)
				rate_down_counter_reg <= rate_down_counter_reg - 7'h01;
			if (bus_start)
				status_reg[`TWSP_ST_START] <= 1'b1;
			if (bus_stop)
				status_reg[`TWSP_ST_STOP] <= 1'b1;
			if (stretch_reg && ctrl_reg[`TWSP_CT_RELEASE])
				stretch_reg <= 1'b0;
			if (!port_enable)
			begin
				status_reg[`TWSP_ST_START] <= 1'b0;
				status_reg[`TWSP_ST_STOP]  <= 1'b0;
				sl_state_reg  <= SL_IDLE;
				ack_drv_reg   <= 1'b0;
				tx_en_reg     <= 1'b0;
				stretch_reg   <= 1'b0;
				m_state_reg   <= M_IDLE;
				m_scl_low_reg <= 1'b0;
				m_sda_low_reg <= 1'b0;
			end
			else if (slave_on)
			begin
				m_state_reg   <= M_IDLE;
				m_scl_low_reg <= 1'b0;
				m_sda_low_reg <= 1'b0;
				if (bus_start)
				begin
					sl_state_reg <= SL_ADDR;
					bitcnt_reg   <= 4'h0;
					ack_drv_reg  <= 1'b0;
					tx_en_reg    <= 1'b0;
					stretch_reg  <= 1'b0;
				end
				else if (bus_stop)
				begin
					sl_state_reg <= SL_IDLE;
					ack_drv_reg  <= 1'b0;
					tx_en_reg    <= 1'b0;
					stretch_reg  <= 1'b0;
				end
				else
				begin
					case (sl_state_reg)
						SL_ADDR, SL_RX:
						begin
							if (scl_rise && bitcnt_reg != `TWSP_BIT_ACK)
							begin
								bitcnt_reg <= bitcnt_reg + 4'h1;
								if (bitcnt_reg != `TWSP_BIT_LAST &&
									(sl_state_reg == SL_ADDR || !edge_sel))
									sr_reg <= sh_in;
							end
							// falling-edge latch shifts bits one to seven on the falls
							if (scl_fall && sl_state_reg == SL_RX && edge_sel &&
								bitcnt_reg != 4'h0 && bitcnt_reg < `TWSP_BIT_LAST)
								sr_reg <= sh_in;
							if (scl_fall && bitcnt_reg == `TWSP_BIT_LAST)
							begin
								sr_reg <= rx_byte;
								if (sl_state_reg == SL_ADDR && power_down_i)
								begin
									sl_state_reg <= SL_WAIT;
									if (own_hit || gc_hit)
									begin
										ctrl_reg[`TWSP_CT_WAKE] <= 1'b1;
										wake_o <= 1'b1;
									end
								end
								else if (sl_state_reg == SL_ADDR && !own_hit && !gc_hit)
									sl_state_reg <= SL_WAIT;
								else
								begin
									if (sl_state_reg == SL_ADDR)
										status_reg[`TWSP_ST_RW] <= rx_byte[0];
									if (bad_rx)
										ctrl_reg[`TWSP_CT_OVF] <= 1'b1;
									else
									begin
										buf_reg <= rx_byte;
										status_reg[`TWSP_ST_BF] <= 1'b1;
										ack_drv_reg <= 1'b1;
									end
								end
							end
							else if (scl_fall && bitcnt_reg == `TWSP_BIT_ACK)
							begin
								ack_drv_reg <= 1'b0;
								bitcnt_reg  <= 4'h0;
								status_reg[`TWSP_ST_IRQ] <= 1'b1;
								if (sl_state_reg == SL_ADDR && status_reg[`TWSP_ST_RW])
								begin
									sl_state_reg <= SL_TX;
									tx_en_reg    <= 1'b1;
									stretch_reg  <= 1'b1;
									ctrl_reg[`TWSP_CT_RELEASE] <= 1'b0;
								end
								else
								begin
									sl_state_reg <= SL_RX;
									if (ctrl_reg[`TWSP_CT_STRETCH])
									begin
										stretch_reg <= 1'b1;
										ctrl_reg[`TWSP_CT_RELEASE] <= 1'b0;
									end
								end
							end
						end
						SL_TX:
						begin
							if (scl_rise)
							begin
								bitcnt_reg <= bitcnt_reg + 4'h1;
								if (bitcnt_reg == `TWSP_BIT_LAST)
								begin
									status_reg[`TWSP_ST_IRQ] <= 1'b1;
									if (sda_s_reg)
										sl_state_reg <= SL_WAIT;
								end
							end
							if (scl_fall)
							begin
								if (bitcnt_reg != 4'h0 && bitcnt_reg != `TWSP_BIT_LAST &&
									bitcnt_reg != `TWSP_BIT_ACK)
									sr_reg <= {sr_reg[6:0], 1'b0};
								if (bitcnt_reg == `TWSP_BIT_LAST)
									tx_en_reg <= 1'b0;
								if (bitcnt_reg == `TWSP_BIT_ACK)
								begin
									bitcnt_reg  <= 4'h0;
									tx_en_reg   <= 1'b1;
									stretch_reg <= 1'b1;
									ctrl_reg[`TWSP_CT_RELEASE] <= 1'b0;
								end
							end
						end
						SL_WAIT:
						begin
							ack_drv_reg <= 1'b0;
							tx_en_reg   <= 1'b0;
						end
						default:
							sl_state_reg <= SL_IDLE;
					endcase
				end
			end
			else
			begin
				sl_state_reg <= SL_IDLE;
				ack_drv_reg  <= 1'b0;
				tx_en_reg    <= 1'b0;
				stretch_reg  <= 1'b0;
				// each period is reload cycles, so a full clock is twice that
				case (m_state_reg)
					M_IDLE:
					begin
						rate_down_counter_reg <= reload_val;
						if (mode2_reg[`TWSP_M2_STARTREQ])
							m_state_reg <= M_S1;
						else if (mode2_reg[`TWSP_M2_RSREQ])
						begin
							m_state_reg   <= M_RS1;
							m_scl_low_reg <= 1'b1;
							m_sda_low_reg <= 1'b0;
						end
						else if (mode2_reg[`TWSP_M2_ACKREQ])
						begin
							m_state_reg   <= M_A1;
							m_scl_low_reg <= 1'b1;
							m_sda_low_reg <= ~mode2_reg[`TWSP_M2_ACKVAL];
						end
						else if (mode2_reg[`TWSP_M2_STOPREQ])
						begin
							m_state_reg   <= M_P1;
							m_scl_low_reg <= 1'b1;
							m_sda_low_reg <= 1'b1;
						end
					end
					M_S1:
					begin
						if (!(scl_s_reg && sda_s_reg))
							rate_down_counter_reg <= reload_val;
						else if (rate_tick)
						begin
							m_sda_low_reg <= 1'b1;
							status_reg[`TWSP_ST_START] <= 1'b1;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_S2;
						end
					end
					M_S2:
						if (rate_tick)
						begin
							mode2_reg[`TWSP_M2_STARTREQ] <= 1'b0;
							status_reg[`TWSP_ST_IRQ] <= 1'b1;
							m_state_reg <= M_IDLE;
						end
					M_RS1:
						if (rate_tick && sda_s_reg)
						begin
							m_scl_low_reg <= 1'b0;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_RS2;
						end
					M_RS2:
					begin
						if (scl_rise && !sda_s_reg)
						begin
							status_reg[`TWSP_ST_BCOL] <= 1'b1;
							mode2_reg[`TWSP_M2_RSREQ] <= 1'b0;
							m_state_reg <= M_IDLE;
						end
						else if (!scl_s_reg)
							rate_down_counter_reg <= reload_val;
						else if (rate_tick)
						begin
							m_sda_low_reg <= 1'b1;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_RS3;
						end
					end
					M_RS3:
						if (rate_tick)
						begin
							mode2_reg[`TWSP_M2_RSREQ] <= 1'b0;
							status_reg[`TWSP_ST_IRQ] <= 1'b1;
							m_state_reg <= M_IDLE;
						end
					M_A1:
						if (rate_tick)
						begin
							m_scl_low_reg <= 1'b0;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_A2;
						end
					M_A2:
					begin
						if (!scl_s_reg)
							rate_down_counter_reg <= reload_val;
						else if (rate_tick)
						begin
							m_scl_low_reg <= 1'b1;
							mode2_reg[`TWSP_M2_ACKREQ] <= 1'b0;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_A3;
						end
					end
					M_A3:
						if (rate_tick)
						begin
							status_reg[`TWSP_ST_IRQ] <= 1'b1;
							m_state_reg <= M_IDLE;
						end
					M_P1:
						if (rate_tick)
						begin
							m_scl_low_reg <= 1'b0;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_P2;
						end
					M_P2:
					begin
						if (!scl_s_reg)
							rate_down_counter_reg <= reload_val;
						else if (rate_tick)
						begin
							m_sda_low_reg <= 1'b0;
							rate_down_counter_reg <= reload_val;
							m_state_reg <= M_P3;
						end
					end
					M_P3:
						if (rate_tick)
						begin
							mode2_reg[`TWSP_M2_STOPREQ] <= 1'b0;
							status_reg[`TWSP_ST_IRQ] <= 1'b1;
							m_state_reg <= M_IDLE;
						end
					default:
						m_state_reg <= M_IDLE;
				endcase
			end
		end
	end
endmodule // twsp_core
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking testbench of the two-wire serial port core
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, power_down_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, wake_o, irq_o, m_scl, m_sda, re_d = 1'b0;
	// pull-ups on both lines
	wire logic  scl_i = !(scl_oe_o || m_scl);
	wire logic  sda_i = !(sda_oe_o || m_sda);
	int         err_total = 0, checks = 0, wakes = 0;
	logic [31:0] seed = 32'd17123;
	logic [15:0] expq[$];
	twsp_core uut (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .scl_i, .scl_o,
		.scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .power_down_i, .wake_o, .irq_o);
	twsp_far_master far (.clk_i, .scl_i, .sda_i, .scl_oe_o(m_scl), .sda_oe_o(m_sda));
	always #25 clk_i = ~clk_i;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask
	// read with expected value and mask of the bits that matter
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		expq.push_back({e, m});
		@(posedge clk_i);
		re_i <= 1'b0;
	endtask
	always @(posedge clk_i)
		re_d <= re_i;
	always @(negedge clk_i)
		if (re_d)
		begin
			logic [15:0] q;
			q = expq.pop_front();
			chk(rdata_o & q[7:0], q[15:8] & q[7:0]);
		end
	always @(posedge clk_i)
		if (wake_o === 1'b1)
			wakes++;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		logic ack;
		logic [7:0] a, d1, d2, d3, rx;
		int w0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++)
			rd(i[2:0], 8'h00, 8'hff);
		a = ((rnd() % 8'd120) + 8'd2) << 1;
		wr(3'h4, a);
		wr(3'h1, 8'h80);
		far.start();
		far.put_byte(a, ack);
		chk({7'h0, ack}, 8'h00);
		rd(3'h0, 8'h21, 8'h25);
		rd(3'h3, a, 8'hff);
		rd(3'h0, 8'h00, 8'h01);
		wr(3'h0, 8'h00);
		d1 = rnd();
		d2 = rnd();
		far.put_byte(d1, ack);
		chk({7'h0, ack}, 8'h00);
		far.put_byte(d2, ack);
		chk({7'h0, ack}, 8'h01);
		rd(3'h1, 8'hc0, 8'hff);
		rd(3'h0, 8'h21, 8'h21);
		rd(3'h3, d1, 8'hff);
		wr(3'h1, 8'ha8);
		rd(3'h1, 8'ha8, 8'hff);
		d3 = rnd();
		far.put_byte(d3, ack);
		chk({7'h0, scl_oe_o}, 8'h01);
		wr(3'h1, 8'hb8);
		rd(3'h3, d3, 8'hff);
		far.stop();
		rd(3'h0, 8'h10, 8'h10);
		wr(3'h1, 8'h00);
		rd(3'h0, 8'h00, 8'h18);
		wr(3'h1, 8'h80);
		wr(3'h0, 8'h00);
		far.start();
		far.put_byte(a | 8'h01, ack);
		chk({7'h0, ack}, 8'h00);
		rd(3'h0, 8'h24, 8'h24);
		rd(3'h3, a | 8'h01, 8'hff);
		chk({7'h0, scl_oe_o}, 8'h01);
		wr(3'h0, 8'h00);
		d1 = rnd();
		wr(3'h3, d1);
		wr(3'h1, 8'h90);
		far.get_byte(1'b1, rx);
		chk(rx, d1);
		rd(3'h0, 8'h20, 8'h20);
		far.stop();
		wr(3'h2, 8'h80);
		wr(3'h0, 8'h00);
		far.start();
		far.put_byte(8'h00, ack);
		chk({7'h0, ack}, 8'h00);
		rd(3'h0, 8'h21, 8'h21);
		rd(3'h3, 8'h00, 8'hff);
		far.stop();
		wr(3'h2, 8'h00);
		wr(3'h0, 8'h00);
		power_down_i <= 1'b1;
		w0 = wakes;
		far.start();
		far.put_byte(a, ack);
		chk({7'h0, ack}, 8'h01);
		chk(8'(wakes - w0), 8'h01);
		rd(3'h0, 8'h00, 8'h21);
		far.start();
		far.put_byte(a ^ 8'h02, ack);
		chk({7'h0, ack}, 8'h01);
		chk(8'(wakes - w0), 8'h01);
		far.stop();
		power_down_i <= 1'b0;
		wr(3'h4, 8'h04);
		wr(3'h1, 8'h81);
		wr(3'h2, 8'h01);
		wr(3'h3, 8'h55);
		for (int i = 0; i < 200 && sda_oe_o !== 1'b1; i++)
			@(posedge clk_i);
		repeat (20) @(posedge clk_i);
		rd(3'h0, 8'h68, 8'h68);
		rd(3'h2, 8'h00, 8'h01);
		rd(3'h3, 8'h00, 8'hff);
		chk({7'h0, irq_o}, 8'h00);
		wr(3'h1, 8'h83);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq_o}, 8'h01);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h02);
		repeat (60) @(posedge clk_i);
		rd(3'h0, 8'h20, 8'ha0);
		rd(3'h2, 8'h00, 8'h02);
		chk({6'h0, scl_oe_o, sda_oe_o}, 8'h01);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h10);
		repeat (60) @(posedge clk_i);
		rd(3'h0, 8'h20, 8'h20);
		rd(3'h2, 8'h00, 8'h10);
		chk({6'h0, scl_oe_o, sda_oe_o}, 8'h03);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h04);
		for (int i = 0; i < 200 && sda_oe_o !== 1'b0; i++)
			@(posedge clk_i);
		repeat (20) @(posedge clk_i);
		rd(3'h0, 8'h30, 8'h30);
		wr(3'h1, 8'h00);
		rd(3'h0, 8'h00, 8'h18);
		wr(3'h1, 8'h80);
		wr(3'h2, 8'h01);
		repeat (10) @(posedge clk_i);
		chk({7'h0, sda_oe_o}, 8'h00);
		repeat (4) @(posedge clk_i);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire

// *** verification/twsp_far_master.sv ***
// far-end bus master model driving the open-drain lines
`default_nettype none
module twsp_far_master (
	// clock
	input  wire logic clk_i,
	// wired line levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	// pull-down enables
	output var logic  scl_oe_o,
	output var logic  sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 12;
	initial
	begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// release clock and wait out a stretching slave
	task automatic rel_clk();
		scl_oe_o <= 1'b0;
		hold(1);
		for (int i = 0; i < 4000 && scl_i !== 1'b1; i++)
			hold(1);
		hold(HALF);
	endtask
	task automatic pulse(output logic b);
		rel_clk();
		b = sda_i;
		scl_oe_o <= 1'b1;
		hold(HALF);
	endtask
	task automatic start();
		sda_oe_o <= 1'b0;
		hold(HALF);
		rel_clk();
		sda_oe_o <= 1'b1;
		hold(HALF);
		scl_oe_o <= 1'b1;
		hold(HALF);
	endtask
	task automatic stop();
		sda_oe_o <= 1'b1;
		hold(HALF);
		rel_clk();
		sda_oe_o <= 1'b0;
		hold(HALF);
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			sda_oe_o <= !d[i];
			hold(HALF);
			pulse(b);
		end
		sda_oe_o <= 1'b0;
		hold(HALF);
		pulse(ack);
	endtask
	// acknowledge level given on the ninth clock
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic b;
		sda_oe_o <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			hold(HALF);
			pulse(b);
			d[i] = b;
		end
		sda_oe_o <= !nack;
		hold(HALF);
		pulse(b);
		sda_oe_o <= 1'b0;
	endtask
endmodule // twsp_far_master
`default_nettype wire

// *** verification/twsp_sva.sv ***
// assertion checker for the two-wire serial port core ports
`default_nettype none
module twsp_sva (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// register port
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       we_i,
	input wire logic       re_i,
	input wire logic [7:0] rdata_o,
	// bus pins
	input wire logic       scl_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_o,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	// system
	input wire logic       power_down_i,
	input wire logic       wake_o,
	input wire logic       irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_reg;
	wire logic  wr_ctl = we_i && addr_i == 3'h1;
	wire logic  wr_m2  = we_i && addr_i == 3'h2;
	wire logic  mst    = ctl_reg[7] && ctl_reg[0];
	// shadow of the software-owned control bits
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			ctl_reg <= 8'h00;
		else if (wr_ctl)
			ctl_reg <= wdata_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ODRAIN: assert property (!scl_o && !sda_o)
		else $error("pin driven high");
	AST_START_SEQ: assert property (wr_m2 && wdata_i[0] && mst && !sda_oe_o && !scl_oe_o |-> ##[1:60] sda_oe_o)
		else $error("start never pulls data low");
	AST_STOP_SEQ: assert property (wr_m2 && wdata_i[2] && mst && sda_oe_o |-> ##[1:80] !sda_oe_o)
		else $error("stop never releases data");
	AST_NOT_MASTER: assert property (wr_m2 && wdata_i[0] && !ctl_reg[0] && !sda_oe_o && !scl_oe_o |=> !sda_oe_o [*8])
		else $error("start acted on in slave mode");
	AST_IRQ_OFF: assert property (wr_ctl && !wdata_i[1] |-> ##2 !irq_o)
		else $error("interrupt while disabled");
	AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
		else $error("wake longer than a pulse");
	AST_WAKE_PD: assert property (wake_o |-> $past(power_down_i))
		else $error("wake outside power down");
	AST_PD_NACK: assert property (power_down_i && !mst |-> !sda_oe_o)
		else $error("acknowledge in power down");
endmodule // twsp_sva
bind twsp_core twsp_sva u_sva (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
	.scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .power_down_i, .wake_o, .irq_o);
`default_nettype wire
